// >>> sisp_defs.svh
// constants of the serial in-system programming link and both of its ends
// What this block does
// - programming only while target reset pin low
// - program/erase refused until programming-enable executed
// - device samples MOSI on rising SCK
// - device shifts MISO on falling SCK
// - host SCK phases exceed three CPU cycles
// - host holds reset and SCK low initially
// - host waits 20 ms before programming-enable
// - device echoes 0x53 during third enable byte
// - host always shifts all four bytes
// - no echo: pulse reset, resend programming-enable
// - page load carries 6 word bits, byte
// - host keeps queue order; low/high load order is the user's
// - page write with 7 MSB commits buffer
// - host idles link during flash write delay
// - waits 4.5/3.6/9.0 ms after writes, erase
// - EEPROM byte write auto-erases location
// - EEPROM byte write carries address and data
// - EEPROM page: 2 LSB load, commit
// - EEPROM page commit alters only loaded bytes
// - chip erase sets both arrays to 0xFF
// - read returns data during final byte
// - reset pin high leaves programming mode
// - poll answer bit 0 high while busy
`ifndef SISP_DEFS_SVH
`define SISP_DEFS_SVH

`define SISP_CLK_MHZ 20
`define SISP_SCK_MIN_PHASE_CYC 3
`define SISP_HALF_CYC (`SISP_SCK_MIN_PHASE_CYC + 1)
`define SISP_RST_PULSE_CYC 2
`define SISP_PWR_WAIT_US 20000
`define SISP_FLASH_WAIT_US 4500
`define SISP_FUSE_WAIT_US 4500
`define SISP_EE_WAIT_US 3600
`define SISP_ERASE_WAIT_US 9000
`define SISP_PWR_WAIT_CYC (`SISP_PWR_WAIT_US * `SISP_CLK_MHZ)
`define SISP_FLASH_WAIT_CYC (`SISP_FLASH_WAIT_US * `SISP_CLK_MHZ)
`define SISP_FUSE_WAIT_CYC (`SISP_FUSE_WAIT_US * `SISP_CLK_MHZ)
`define SISP_EE_WAIT_CYC (`SISP_EE_WAIT_US * `SISP_CLK_MHZ)
`define SISP_ERASE_WAIT_CYC (`SISP_ERASE_WAIT_US * `SISP_CLK_MHZ)

`define SISP_WORD_BITS 6
`define SISP_PAGE_BITS 7
`define SISP_EE_OFF_BITS 2
`define SISP_EE_BYTES 512
`define SISP_FIFO_W 32
`define SISP_FIFO_D 16
`define SISP_RETRY_MAX 2'h3

`define SISP_OP_PROG 8'hac
`define SISP_PE_ECHO 8'h53
`define SISP_SUB_ERASE 8'h80
`define SISP_SUB_LOCK 8'he0
`define SISP_SUB_FUSE_LO 8'ha0
`define SISP_SUB_FUSE_HI 8'ha8
`define SISP_SUB_FUSE_EXT 8'ha4
`define SISP_OP_POLL 8'hf0
`define SISP_OP_LD_LO 8'h40
`define SISP_OP_LD_HI 8'h48
`define SISP_OP_WR_PAGE 8'h4c
`define SISP_OP_RD_LO 8'h20
`define SISP_OP_RD_HI 8'h28
`define SISP_OP_EE_RD 8'ha0
`define SISP_OP_EE_WR 8'hc0
`define SISP_OP_EE_LD 8'hc1
`define SISP_OP_EE_PAGE 8'hc2
`define SISP_OP_RD_LOCK 8'h58
`define SISP_OP_RD_FUSE 8'h50
`define SISP_SUB_HI 8'h08
`define SISP_OP_RD_SIG 8'h30
`define SISP_OP_RD_CAL 8'h38
`define SISP_ERASED 8'hff

`endif

// >>> sisp_pkg.sv
// types shared by both ends of the programming link
`default_nettype none
package sisp_pkg;
`include "sisp_defs.svh"

    typedef enum logic [2:0] {
        SISP_H_WAIT, SISP_H_RUN, SISP_H_IDLE, SISP_H_SHIFT, SISP_H_PULSE, SISP_H_HOLD
    } sisp_hst_e;

    typedef struct packed {
        logic sck_m, sck_s, sck_d, mosi_m, mosi_s, rpin_m, rpin_s;
        logic [4:0] bitcnt;
        logic [31:0] rx;
        logic [7:0] tx;
        logic en;
        logic [7:0] lock, fuse_lo, fuse_hi, fuse_ext;
        logic [17:0] busy_cnt;
        logic cmt_on;
        logic [5:0] cmt_idx;
        logic [6:0] page;
        logic fl_we, fl_erase;
        logic [12:0] fl_addr;
        logic [15:0] fl_wdata;
        logic [63:0][15:0] pbuf;
        logic [3:0][7:0] epbuf;
        logic [3:0] emask;
        logic [511:0][7:0] ee;
    } sisp_dev_s;

    typedef struct packed {
        sisp_hst_e st;
        logic [1:0] ph;
        logic [4:0] bitn;
        logic [31:0] sh, cmd, rx;
        logic [18:0] tmr, want;
        logic sck, mosi, rpin_b, miso_m, miso_s;
        logic rsp_v, serr;
        logic [31:0] rsp;
        logic [1:0] retry;
    } sisp_host_s;
endpackage
`default_nettype wire

// >>> sisp_if.sv
// four-wire programming link between programmer and target
`default_nettype none
interface sisp_if;
    logic sck;
    logic mosi;
    logic miso;
    logic prog_rst_b;
    modport host (output sck, output mosi, output prog_rst_b, input miso);
    modport dev (input sck, input mosi, input prog_rst_b, output miso);
endinterface
`default_nettype wire

// >>> sisp_dev.sv
// target end: serial programming slave with flash page buffer and eeprom
`default_nettype none
`include "sisp_defs.svh"
module sisp_dev
    import sisp_pkg::*;
#(
    parameter int unsigned FLASH_WAIT_CYC = `SISP_FLASH_WAIT_CYC,
    parameter int unsigned FUSE_WAIT_CYC = `SISP_FUSE_WAIT_CYC,
    parameter int unsigned EE_WAIT_CYC = `SISP_EE_WAIT_CYC,
    parameter int unsigned ERASE_WAIT_CYC = `SISP_ERASE_WAIT_CYC,
    // arbitrary identification values
    parameter logic [23:0] SIG_BYTES = 24'h0a0b0c,
    parameter logic [7:0] CAL_BYTE = 8'h5a
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link
    sisp_if.dev bus,
    // flash array port
    output logic flash_we,
    output logic flash_erase,
    output logic [12:0] flash_addr,
    output logic [15:0] flash_wdata,
    input wire logic [15:0] flash_rdata,
    // status
    output logic prog_mode,
    output logic nvm_busy
);

    sisp_dev_s st_r;
    sisp_dev_s st_nxt;

    // answer byte for the last byte of a read, from the first three bytes
    function automatic logic [7:0] rd_byte(input sisp_dev_s s, input logic [15:0] fd);
        logic [7:0] op;
        logic [7:0] b2;
        logic [7:0] b3;
        op = s.rx[23:16];
        b2 = s.rx[15:8];
        b3 = s.rx[7:0];
        case (op)
            `SISP_OP_POLL: rd_byte = {7'h00, (s.busy_cnt != 18'h00000) | s.cmt_on};
            `SISP_OP_RD_LO: rd_byte = fd[7:0];
            `SISP_OP_RD_HI: rd_byte = fd[15:8];
            `SISP_OP_EE_RD: rd_byte = s.ee[{b2[0], b3}];
            `SISP_OP_RD_LOCK: rd_byte = (b2 == `SISP_SUB_HI) ? s.fuse_hi : s.lock;
            `SISP_OP_RD_FUSE: rd_byte = (b2 == `SISP_SUB_HI) ? s.fuse_ext : s.fuse_lo;
            `SISP_OP_RD_SIG: begin
                case (b3[1:0])
                    2'h0: rd_byte = SIG_BYTES[23:16];
                    2'h1: rd_byte = SIG_BYTES[15:8];
                    default: rd_byte = SIG_BYTES[7:0];
                endcase
            end
            `SISP_OP_RD_CAL: rd_byte = CAL_BYTE;
            default: rd_byte = b3;
        endcase
    endfunction

    always_comb begin
        logic [31:0] w;
        logic rise;
        logic fall;
        logic allowed;
        w = {st_r.rx[30:0], st_r.mosi_s};
        rise = st_r.sck_s & ~st_r.sck_d;
        fall = ~st_r.sck_s & st_r.sck_d;
        allowed = st_r.en && (st_r.busy_cnt == 18'h00000) && !st_r.cmt_on;
        st_nxt = st_r;
        // pins pass two flops before anything looks at them
        st_nxt.sck_m = bus.sck;
        st_nxt.sck_s = st_r.sck_m;
        st_nxt.sck_d = st_r.sck_s;
        st_nxt.mosi_m = bus.mosi;
        st_nxt.mosi_s = st_r.mosi_m;
        st_nxt.rpin_m = bus.prog_rst_b;
        st_nxt.rpin_s = st_r.rpin_m;
        st_nxt.fl_we = 1'b0;
        st_nxt.fl_erase = 1'b0;
        if (st_r.busy_cnt != 18'h00000) begin
            st_nxt.busy_cnt = st_r.busy_cnt - 18'h00001;
        end
        // page is streamed to the array one word per cycle, well inside the wait
        if (st_r.cmt_on) begin
            st_nxt.fl_we = 1'b1;
            st_nxt.fl_addr = {st_r.page, st_r.cmt_idx};
            st_nxt.fl_wdata = st_r.pbuf[st_r.cmt_idx];
            st_nxt.cmt_idx = st_r.cmt_idx + 6'h01;
            if (st_r.cmt_idx == 6'h3f) begin
                st_nxt.cmt_on = 1'b0;
            end
        end
        if (st_r.rpin_s) begin
            // released target runs normally; a partial frame is dropped
            st_nxt.bitcnt = 5'h00;
            st_nxt.en = 1'b0;
            st_nxt.tx = 8'h00;
        end else if (rise) begin
            st_nxt.rx = w;
            st_nxt.bitcnt = st_r.bitcnt + 5'h01;
            if (st_r.bitcnt == 5'h17 && !st_r.cmt_on) begin
                st_nxt.fl_addr = w[12:0];
            end
            if (st_r.bitcnt == 5'h1f) begin
                if (w[31:24] == `SISP_OP_PROG && w[23:16] == `SISP_PE_ECHO) begin
                    st_nxt.en = 1'b1;
                end else if (allowed) begin
                    case (w[31:24])
                        `SISP_OP_LD_LO: st_nxt.pbuf[w[13:8]][7:0] = w[7:0];
                        `SISP_OP_LD_HI: st_nxt.pbuf[w[13:8]][15:8] = w[7:0];
                        `SISP_OP_WR_PAGE: begin
                            st_nxt.page = {w[20:16], w[15:14]};
                            st_nxt.cmt_on = 1'b1;
                            st_nxt.cmt_idx = 6'h00;
                            st_nxt.busy_cnt = 18'(FLASH_WAIT_CYC);
                        end
                        `SISP_OP_EE_WR: begin
                            // write overwrites whole byte, erase step is implicit
                            st_nxt.ee[{w[16], w[15:8]}] = w[7:0];
                            st_nxt.busy_cnt = 18'(EE_WAIT_CYC);
                        end
                        `SISP_OP_EE_LD: begin
                            st_nxt.epbuf[w[9:8]] = w[7:0];
                            st_nxt.emask[w[9:8]] = 1'b1;
                        end
                        `SISP_OP_EE_PAGE: begin
                            for (int i = 0; i < 4; i++) begin
                                if (st_r.emask[i]) begin
                                    st_nxt.ee[{w[16], w[15:10], 2'(i)}] = st_r.epbuf[i];
                                end
                            end
                            st_nxt.emask = 4'h0;
                            st_nxt.busy_cnt = 18'(EE_WAIT_CYC);
                        end
                        `SISP_OP_PROG: begin
                            case (w[23:16])
                                `SISP_SUB_ERASE: begin
                                    st_nxt.ee = '1;
                                    st_nxt.fl_erase = 1'b1;
                                    st_nxt.lock = `SISP_ERASED;
                                    st_nxt.emask = 4'h0;
                                    st_nxt.busy_cnt = 18'(ERASE_WAIT_CYC);
                                end
                                `SISP_SUB_LOCK: begin
                                    // lock bits only program; erase clears them
                                    st_nxt.lock = st_r.lock & w[7:0];
                                    st_nxt.busy_cnt = 18'(FUSE_WAIT_CYC);
                                end
                                `SISP_SUB_FUSE_LO: begin
                                    st_nxt.fuse_lo = w[7:0];
                                    st_nxt.busy_cnt = 18'(FUSE_WAIT_CYC);
                                end
                                `SISP_SUB_FUSE_HI: begin
                                    st_nxt.fuse_hi = w[7:0];
                                    st_nxt.busy_cnt = 18'(FUSE_WAIT_CYC);
                                end
                                `SISP_SUB_FUSE_EXT: begin
                                    st_nxt.fuse_ext = w[7:0];
                                    st_nxt.busy_cnt = 18'(FUSE_WAIT_CYC);
                                end
                                default: begin
                                end
                            endcase
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end else if (fall) begin
            if (st_r.bitcnt[2:0] == 3'h0) begin
                if (st_r.bitcnt == 5'h00) begin
                    st_nxt.tx = 8'h00;
                end else if (st_r.bitcnt == 5'h18) begin
                    st_nxt.tx = rd_byte(st_r, flash_rdata);
                end else begin
                    st_nxt.tx = st_r.rx[7:0];
                end
            end else begin
                st_nxt.tx = {st_r.tx[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.rpin_m <= 1'b1;
            st_r.rpin_s <= 1'b1;
            st_r.lock <= `SISP_ERASED;
            st_r.fuse_lo <= `SISP_ERASED;
            st_r.fuse_hi <= `SISP_ERASED;
            st_r.fuse_ext <= `SISP_ERASED;
            st_r.pbuf <= '1;
            st_r.epbuf <= '1;
            st_r.ee <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.miso = st_r.tx[7];
    assign flash_we = st_r.fl_we;
    assign flash_erase = st_r.fl_erase;
    assign flash_addr = st_r.fl_addr;
    assign flash_wdata = st_r.fl_wdata;
    assign prog_mode = st_r.en;
    assign nvm_busy = (st_r.busy_cnt != 18'h00000) | st_r.cmt_on;

endmodule
`default_nettype wire

// >>> sisp_host.sv
// programmer end: command fifo and four-byte link master
`default_nettype none
`include "sisp_defs.svh"
module sisp_fifo #(
    parameter int W = 32,
    parameter int D = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } sisp_fifo_s;

    sisp_fifo_s st_r;
    sisp_fifo_s st_nxt;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(D - 1)) ? '0 : p + AW'(1);
    endfunction

    assign in_ready = st_r.cnt != CW'(D);
    assign out_valid = st_r.cnt != '0;
    assign out_data = st_r.mem[st_r.rp];

    always_comb begin
        logic push;
        logic pop;
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = bump(st_r.wp);
        end
        if (pop) begin
            st_nxt.rp = bump(st_r.rp);
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

module sisp_host
    import sisp_pkg::*;
#(
    parameter int unsigned PWR_WAIT_CYC = `SISP_PWR_WAIT_CYC,
    parameter int unsigned FLASH_WAIT_CYC = `SISP_FLASH_WAIT_CYC,
    parameter int unsigned FUSE_WAIT_CYC = `SISP_FUSE_WAIT_CYC,
    parameter int unsigned EE_WAIT_CYC = `SISP_EE_WAIT_CYC,
    parameter int unsigned ERASE_WAIT_CYC = `SISP_ERASE_WAIT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link
    sisp_if.host bus,
    // commands
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [31:0] cmd_word,
    // answers
    output logic rsp_valid,
    output logic [31:0] rsp_word,
    output logic rsp_sync_err,
    // session control
    input wire logic run_target
);

    sisp_host_s st_r;
    sisp_host_s st_nxt;
    logic q_valid;
    logic q_ready;
    logic [31:0] q_word;

    // order of commands is kept, so byte load order is the user's
    sisp_fifo #(.W(`SISP_FIFO_W), .D(`SISP_FIFO_D)) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd_word),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_word)
    );

    // no ready polling: every write simply sits out its fixed delay
    function automatic logic [18:0] wait_for(input logic [31:0] c);
        wait_for = 19'h00000;
        case (c[31:24])
            `SISP_OP_WR_PAGE: wait_for = 19'(FLASH_WAIT_CYC);
            `SISP_OP_EE_WR, `SISP_OP_EE_PAGE: wait_for = 19'(EE_WAIT_CYC);
            `SISP_OP_PROG: begin
                case (c[23:16])
                    `SISP_SUB_ERASE: wait_for = 19'(ERASE_WAIT_CYC);
                    `SISP_SUB_LOCK, `SISP_SUB_FUSE_LO, `SISP_SUB_FUSE_HI, `SISP_SUB_FUSE_EXT:
                        wait_for = 19'(FUSE_WAIT_CYC);
                    default: wait_for = 19'h00000;
                endcase
            end
            default: wait_for = 19'h00000;
        endcase
    endfunction

    assign q_ready = (st_r.st == SISP_H_IDLE) && !run_target;

    always_comb begin
        logic [31:0] rxn;
        logic miss;
        rxn = {st_r.rx[30:0], st_r.miso_s};
        miss = (st_r.cmd[31:16] == {`SISP_OP_PROG, `SISP_PE_ECHO}) && (rxn[15:8] != `SISP_PE_ECHO);
        st_nxt = st_r;
        st_nxt.miso_m = bus.miso;
        st_nxt.miso_s = st_r.miso_m;
        st_nxt.mosi = st_r.sh[31];
        st_nxt.rsp_v = 1'b0;
        case (st_r.st)
            SISP_H_WAIT: begin
                st_nxt.sck = 1'b0;
                st_nxt.rpin_b = 1'b0;
                if (run_target) begin
                    st_nxt.st = SISP_H_RUN;
                    st_nxt.rpin_b = 1'b1;
                end else if (st_r.tmr >= 19'(PWR_WAIT_CYC)) begin
                    st_nxt.st = SISP_H_IDLE;
                end else begin
                    st_nxt.tmr = st_r.tmr + 19'h00001;
                end
            end
            SISP_H_RUN: begin
                if (!run_target) begin
                    st_nxt.st = SISP_H_WAIT;
                    st_nxt.rpin_b = 1'b0;
                    st_nxt.tmr = 19'h00000;
                end
            end
            SISP_H_IDLE: begin
                if (run_target) begin
                    st_nxt.st = SISP_H_RUN;
                    st_nxt.rpin_b = 1'b1;
                end else if (q_valid) begin
                    st_nxt.cmd = q_word;
                    st_nxt.sh = q_word;
                    st_nxt.bitn = 5'h00;
                    st_nxt.ph = 2'h0;
                    st_nxt.retry = 2'h0;
                    st_nxt.st = SISP_H_SHIFT;
                end
            end
            SISP_H_SHIFT: begin
                st_nxt.ph = st_r.ph + 2'h1;
                if (st_r.ph == 2'(`SISP_HALF_CYC - 1)) begin
                    st_nxt.ph = 2'h0;
                    if (!st_r.sck) begin
                        st_nxt.sck = 1'b1;
                    end else begin
                        // miso sampled late in the high phase, after the target's update
                        st_nxt.sck = 1'b0;
                        st_nxt.rx = rxn;
                        st_nxt.sh = {st_r.sh[30:0], 1'b0};
                        st_nxt.bitn = st_r.bitn + 5'h01;
                        st_nxt.tmr = 19'h00000;
                        if (st_r.bitn == 5'h1f) begin
                            if (miss && st_r.retry != `SISP_RETRY_MAX) begin
                                st_nxt.st = SISP_H_PULSE;
                                st_nxt.rpin_b = 1'b1;
                                st_nxt.retry = st_r.retry + 2'h1;
                            end else begin
                                st_nxt.rsp_v = 1'b1;
                                st_nxt.rsp = rxn;
                                st_nxt.serr = miss;
                                st_nxt.want = wait_for(st_r.cmd);
                                st_nxt.st = SISP_H_HOLD;
                            end
                        end
                    end
                end
            end
            SISP_H_PULSE: begin
                if (st_r.tmr >= 19'(`SISP_RST_PULSE_CYC - 1)) begin
                    st_nxt.rpin_b = 1'b0;
                    st_nxt.sh = st_r.cmd;
                    st_nxt.bitn = 5'h00;
                    st_nxt.ph = 2'h0;
                    st_nxt.st = SISP_H_SHIFT;
                end else begin
                    st_nxt.tmr = st_r.tmr + 19'h00001;
                end
            end
            SISP_H_HOLD: begin
                if (st_r.tmr >= st_r.want) begin
                    st_nxt.st = SISP_H_IDLE;
                end else begin
                    st_nxt.tmr = st_r.tmr + 19'h00001;
                end
            end
            default: st_nxt.st = SISP_H_WAIT;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.sck = st_r.sck;
    assign bus.mosi = st_r.mosi;
    assign bus.prog_rst_b = st_r.rpin_b;
    assign rsp_valid = st_r.rsp_v;
    assign rsp_word = st_r.rsp;
    assign rsp_sync_err = st_r.serr;

endmodule
`default_nettype wire

// >>> sisp_asserts.sv
// wire-level checks of the programming link
`default_nettype none
module sisp_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic prog_rst_b
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sck_q;
    logic rise;
    logic [4:0] n_r;
    logic [15:0] sm_r;
    logic [7:0] ss_r;
    assign rise = sck && !sck_q;
    // miso is taken at the rising edge, where it has long settled
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_q <= 1'b0;
            n_r <= 5'h00;
            sm_r <= 16'h0000;
            ss_r <= 8'h00;
        end else begin
            sck_q <= sck;
            n_r <= prog_rst_b ? 5'h00 : n_r + 5'(rise);
            if (rise) begin
                sm_r <= {sm_r[14:0], mosi};
                ss_r <= {ss_r[6:0], miso};
            end
        end
    end
    sequence s_en_in;
        rise && n_r == 5'h0f ##1 sm_r == 16'hac53;
    endsequence
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_sck_high_len: assert property ($rose(sck) |-> sck [*4]) else $error("sck high phase short");
    a_sck_low_len: assert property ($fell(sck) |-> !sck [*4]) else $error("sck low phase short");
    a_pin_idle: assert property (prog_rst_b |-> !sck) else $error("sck toggles with pin high");
    a_pulse_len: assert property ($rose(prog_rst_b) |-> prog_rst_b [*2]) else $error("pin pulse short");
    a_miso_shift: assert property ($changed(miso) |-> !sck) else $error("miso moved in high phase");
    a_mosi_stable: assert property (sck |-> $stable(mosi)) else $error("mosi moved in high phase");
    a_whole_frame: assert property ($rose(prog_rst_b) |-> n_r == 5'h00) else $error("partial frame");
    // echo shows after the 24th rise, eight sck periods after the second byte
    a_enable_echo: assert property (s_en_in |-> ##[60:75] (n_r == 5'h18 && ss_r == 8'h53))
        else $error("enable echo missing");
endmodule
`default_nettype wire

// >>> sisp_tb.sv
// bench: programmer and target joined on one link
`default_nettype none
module sisp_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid = 1'b0;
    logic run_target = 1'b0;
    logic [31:0] cmd_word = 32'h0;
    logic cmd_ready, rsp_valid, rsp_sync_err, prog_mode, fl_we, fl_er, busy;
    logic [12:0] fl_a;
    logic [15:0] fl_wd;
    logic [31:0] rsp_word, r;
    logic [15:0] flash [8192];
    int n_fail = 0;
    int n_tests = 0;
    int n_we = 0;
    sisp_if lnk();
    // shortened waits, equal on both ends; fuse waits keep defaults as no fuse is written
    localparam int unsigned PWR_CYC = 200;
    localparam int unsigned FL_CYC = 100;
    localparam int unsigned EE_CYC = 80;
    localparam int unsigned ER_CYC = 160;
    sisp_host #(.PWR_WAIT_CYC(PWR_CYC), .FLASH_WAIT_CYC(FL_CYC), .EE_WAIT_CYC(EE_CYC),
        .ERASE_WAIT_CYC(ER_CYC)) sisp_host_i (.clk(clk), .rst_b(rst_b), .bus(lnk), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
        .rsp_sync_err(rsp_sync_err), .run_target(run_target));
    sisp_dev #(.FLASH_WAIT_CYC(FL_CYC), .EE_WAIT_CYC(EE_CYC), .ERASE_WAIT_CYC(ER_CYC))
        sisp_dev_i (.clk(clk), .rst_b(rst_b), .bus(lnk), .flash_we(fl_we), .flash_erase(fl_er),
        .flash_addr(fl_a), .flash_wdata(fl_wd), .flash_rdata(flash[fl_a]), .prog_mode(prog_mode),
        .nvm_busy(busy));
    sisp_asserts sisp_asserts_i (.clk(clk), .rst_b(rst_b), .sck(lnk.sck), .mosi(lnk.mosi),
        .miso(lnk.miso), .prog_rst_b(lnk.prog_rst_b));
    initial forever #25 clk = ~clk;
    // flash array outside the target
    always @(posedge clk) begin
        if (fl_er) foreach (flash[i]) flash[i] = 16'hffff;
        else if (fl_we) begin
            flash[fl_a] = fl_wd;
            n_we++;
        end
    end
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // one command through the queue, answer left in r
    task automatic xfer(input logic [31:0] w);
        int k;
        @(negedge clk);
        cmd_word = w;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        for (k = 0; k < 3000 && rsp_valid !== 1'b1; k++) @(negedge clk);
        if (k == 3000) begin
            n_fail++;
            wrap_up();
        end
        r = rsp_word;
    endtask
    task automatic t_refuse();
        xfer(32'h4c000000);
        xfer(32'hf0000000);
        chk("page writes", 0, n_we);
    endtask
    task automatic t_enable();
        xfer(32'hac530000);
        chk("echo", 32'h53, r[15:8]);
        chk("sync", 0, rsp_sync_err);
        chk("prog_mode", 1, prog_mode);
    endtask
    task automatic t_erase();
        // a programmed byte first, so the erase has something to undo
        xfer(32'hc0000312);
        xfer(32'hac800000);
        chk("busy", 1, busy);
        xfer(32'ha0000300);
        chk("ee erased", 32'hff, r[7:0]);
        chk("flash erased", 32'hffff, flash[13'h0]);
    endtask
    task automatic t_flash();
        xfer(32'h40000534);
        xfer(32'h48000512);
        xfer(32'h4c004000);
        xfer(32'h20004500);
        chk("read lo", 32'h34, r[7:0]);
        xfer(32'h28004500);
        chk("read hi", 32'h12, r[7:0]);
        chk("page", 32'h1234, flash[13'h045]);
    endtask
    task automatic t_eeprom();
        xfer(32'hc00010f0);
        xfer(32'hc000100f);
        xfer(32'ha0001000);
        chk("ee byte", 32'h0f, r[7:0]);
        xfer(32'hc1000155);
        xfer(32'hc2001000);
        xfer(32'ha0001000);
        chk("ee kept", 32'h0f, r[7:0]);
        xfer(32'ha0001100);
        chk("ee page", 32'h55, r[7:0]);
        xfer(32'hf0000000);
        chk("poll", 0, r[0]);
    endtask
    // queue filled until refused, then drained
    task automatic t_fifo();
        int k;
        int j;
        int t;
        @(negedge clk);
        cmd_word = 32'hf0000000;
        for (k = 0; cmd_ready === 1'b1 && k < 20; k++) begin
            cmd_valid = 1'b1;
            @(negedge clk);
        end
        cmd_valid = 1'b0;
        chk("refused", 1, k < 20);
        j = 0;
        for (t = 0; j < k && t < 20000; t++) begin
            @(negedge clk);
            if (rsp_valid === 1'b1) j++;
        end
        chk("drained", k, j);
    endtask
    task automatic t_exit();
        int k;
        @(negedge clk);
        run_target = 1'b1;
        for (k = 0; k < 20 && prog_mode !== 1'b0; k++) @(negedge clk);
        chk("prog_mode off", 0, prog_mode);
        chk("pin", 1, lnk.prog_rst_b);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        t_refuse();
        t_enable();
        t_erase();
        t_flash();
        t_eeprom();
        t_fifo();
        t_exit();
        wrap_up();
    end
endmodule
`default_nettype wire
